// ==== flash_sr_asserts.sv ====
// Port checks for the flash status register block
`timescale 1ns/1ps
module flash_sr_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_hw_reset_n,
  input wire logic o_write_enable_latch,
  input wire logic o_suspend_flag,
  input wire logic o_quad_enable_bit,
  input wire logic o_hold_enable,
  input wire logic o_top_bottom_select,
  input wire logic o_current_addr_mode,
  input wire logic o_ext_addr_required,
  input wire logic o_protect_scheme_select,
  input wire logic o_complement_protect_bit,
  input wire logic o_status_lockdown_bit,
  input wire logic [3:0] o_block_protect_field,
  input wire logic [2:0] o_security_lock,
  input wire logic [1:0] o_drive_strength,
  input wire logic [6:0] o_drive_pct
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Hardware reset reloads live copies, so only quiet stretches count
  sequence locked_quiet;
    (o_status_lockdown_bit && i_hw_reset_n) [*4];
  endsequence
  drive_decode_a: assert property (o_drive_pct == (o_drive_strength[1] ?
    (o_drive_strength[0] ? 7'h19 : 7'h32) : (o_drive_strength[0] ? 7'h4b : 7'h64)))
    else $error("drive percent decode wrong");
  hold_inverse_a: assert property (o_hold_enable != o_quad_enable_bit)
    else $error("hold enable wrong");
  addr_inverse_a: assert property (o_ext_addr_required != o_current_addr_mode)
    else $error("extended address flag wrong");
  scheme_gate_a: assert property (o_protect_scheme_select |->
    !o_complement_protect_bit && !o_top_bottom_select && o_block_protect_field == 4'h0)
    else $error("array protect bits active");
  lock_keep_a: assert property (&(o_security_lock | ~$past(o_security_lock)))
    else $error("security lock cleared");
  lockdown_hold_a: assert property (locked_quiet |=> $stable(o_quad_enable_bit))
    else $error("status changed under lock-down");
  reset_default_a: assert property ($fell(i_rst) |->
    !o_write_enable_latch && !o_suspend_flag && o_drive_strength == 2'h3)
    else $error("wrong state after reset");
  suspend_cmd_a: assert property ($changed(o_suspend_flag) && i_hw_reset_n |->
    i_cs_n && $past(i_cs_n, 2))
    else $error("suspend flag moved in a frame");
endmodule
bind flash_status_config_regs flash_sr_asserts u_chk (.*);

// ==== flash_sr_pkg.sv ====
// Constants for the serial flash status and configuration register block
package flash_sr_pkg;

  localparam int unsigned SR_W = 24;

  // Bit positions in the 24-bit status word (three bytes)
  localparam int unsigned BIT_WR_LATCH = 1;
  localparam int unsigned BIT_BLKPROT_LO = 2;
  localparam int unsigned BIT_TOPBOT = 6;
  localparam int unsigned BIT_PROTECT = 7;
  localparam int unsigned BIT_LOCKDOWN = 8;
  localparam int unsigned BIT_QUAD = 9;
  localparam int unsigned BIT_LB_LO = 11;
  localparam int unsigned BIT_COMPL = 14;
  localparam int unsigned BIT_SUSPEND = 15;
  localparam int unsigned BIT_ADDR_MODE = 16;
  localparam int unsigned BIT_PWRUP_MODE = 17;
  localparam int unsigned BIT_SCHEME = 18;
  localparam int unsigned BIT_DRV_LO = 21;

  // Writable bits of each byte; lock bits are handled as set-only
  localparam logic [7:0] SR1_WMASK = 8'hfc;
  localparam logic [7:0] SR2_WMASK = 8'h43;
  localparam logic [7:0] SR2_LBMASK = 8'h38;
  localparam logic [7:0] SR3_WMASK = 8'h64;
  localparam logic [7:0] SR3_PWRUP_MASK = 8'h02;

  // Factory defaults: all protection off, drive strength 25%
  localparam logic [SR_W-1:0] SR_RESET = 24'h600000;

  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_OTP_PRE1 = 8'haa;
  localparam logic [7:0] OP_OTP_PRE2 = 8'h55;
  localparam logic [7:0] OP_EN4B = 8'hb7;
  localparam logic [7:0] OP_EX4B = 8'he9;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE4K = 8'h20;

  // Link bit counter: opcode ends at bit 7, first data byte at bit 15
  localparam logic [4:0] CNT_OP_LAST = 5'h07;
  localparam logic [4:0] CNT_DAT_LAST = 5'h0f;
  localparam logic [4:0] CNT_SAT = 5'h10;

  // Drive strength codes in percent
  localparam logic [6:0] DRV_PCT_00 = 7'h64;
  localparam logic [6:0] DRV_PCT_01 = 7'h4b;
  localparam logic [6:0] DRV_PCT_10 = 7'h32;
  localparam logic [6:0] DRV_PCT_11 = 7'h19;

  typedef enum logic [1:0] {
    OTP_IDLE = 2'b00,
    OTP_PRE1 = 2'b01,
    OTP_ARMED = 2'b10
  } otp_e;

endpackage

// ==== flash_status_config_regs.sv ====
// Status and configuration registers of a serial flash, with serial link front end
// Behaviour
// - Status write needs enable latch, protect/lock permission, and WP only without quad.
// - Lock-down 0, protect 0: WP ignored, write allowed when enable latch set.
// - Lock-down 0, protect 1: WP low rejects every status write while quad enable is 0.
// - Lock-down 0, protect 1: WP high allows write when enable latch set.
// - Lock-down 1 refuses all status writes until power cycle clears it.
// - AAh, 55h prefix before lock-down write makes protection permanent.
// - Suspend command 75h sets read-only suspend flag at bit 15.
// - Resume 7Ah and power cycle clear the suspend flag.
// - Three security lock bits 13..11 default 0, each settable independently.
// - Security lock bits clear only at power cycle; writes can only set them.
// - Quad enable 0 keeps hold active, standard and dual modes only.
// - Quad enable 1 enables extra data lines, disables hold, allows quad.
// - Bit 16 reports address mode: 0 three-byte, 1 four-byte.
// - Power-up address mode bit only used at power-on or reset.
// - Power-up address mode changes only through 06h then 11h.
// - Power-up bit 0 starts 3-byte with extended address; 1 starts 4-byte.
// - Scheme select 0 uses complement/top-bottom/block bits; 1 uses block locks.
// - All individual block locks set at power-on and every reset.
// - Drive field 00=100%, 01=75%, 10=50%, 11=25%; default 11.
// - Reserved bits read 0; writes to them have no effect.
// - Write enable latch set by 06h; cleared by disable, program, erase, accepted status write.
`timescale 1ns/1ps

module flash_status_config_regs
  import flash_sr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic i_wp_n,
  input wire logic i_hw_reset_n,
  output logic o_write_enable_latch,
  output logic o_suspend_flag,
  output logic o_quad_enable_bit,
  output logic o_hold_enable,
  output logic o_current_addr_mode,
  output logic o_ext_addr_required,
  output logic o_protect_scheme_select,
  output logic o_complement_protect_bit,
  output logic o_top_bottom_select,
  output logic [3:0] o_block_protect_field,
  output logic o_block_locks_set,
  output logic [2:0] o_security_lock,
  output logic [1:0] o_drive_strength,
  output logic [6:0] o_drive_pct,
  output logic o_status_lockdown_bit,
  output logic o_status_permanent
);

  function automatic logic [6:0] drv_decode(input logic [1:0] code);
    logic [6:0] pct;
    pct = DRV_PCT_11;
    unique case (code)
      2'b00: pct = DRV_PCT_00;
      2'b01: pct = DRV_PCT_01;
      2'b10: pct = DRV_PCT_10;
      2'b11: pct = DRV_PCT_11;
    endcase
    return pct;
  endfunction

  // Merges one written byte into the status word; only writable bits move
  function automatic logic [SR_W-1:0] sr_merge(
    input logic [SR_W-1:0] cur,
    input logic [1:0] idx,
    input logic [7:0] d,
    input logic nv_path
  );
    logic [SR_W-1:0] nxt;
    logic [7:0] m;
    nxt = cur;
    m = 8'h00;
    unique case (idx)
      2'd0:
      begin
        nxt[7:0] = (cur[7:0] & ~SR1_WMASK) | (d & SR1_WMASK);
      end
      2'd1:
      begin
        nxt[15:8] = (cur[15:8] & ~SR2_WMASK) | (d & SR2_WMASK);
        nxt[15:8] = nxt[15:8] | (d & SR2_LBMASK);
      end
      default:
      begin
        m = nv_path ? (SR3_WMASK | SR3_PWRUP_MASK) : SR3_WMASK;
        nxt[23:16] = (cur[23:16] & ~m) | (d & m);
      end
    endcase
    return nxt;
  endfunction

  // Link domain: serial shift in on rising edge of the link clock

  typedef struct packed {
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] dat;
    logic have_op;
    logic have_dat;
    logic [SR_W-1:0] st_s1;
    logic [SR_W-1:0] st_s2;
  } link_s;

  link_s lk_q;
  link_s lk_d;
  logic [4:0] cnt_q;
  logic so_q;
  logic so_oe_q;
  logic [SR_W-1:0] status_word;

  // Counter and the read-out flops are the only link flops cleared by chip select, since the link
  // clock stops between frames; captured command bytes must outlive the frame.
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      cnt_q <= 5'h00;
    end
    else if (cnt_q != CNT_SAT)
    begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_comb
  begin
    lk_d = lk_q;
    lk_d.sh = {lk_q.sh[6:0], i_si};
    // Core changes the word between frames except on a reset, so it is settled here
    lk_d.st_s1 = status_word;
    lk_d.st_s2 = lk_q.st_s1;
    if (cnt_q == 5'h00)
    begin
      lk_d.have_op = 1'b0;
      lk_d.have_dat = 1'b0;
    end
    if (cnt_q == CNT_OP_LAST)
    begin
      lk_d.op = {lk_q.sh[6:0], i_si};
      lk_d.have_op = 1'b1;
    end
    if (cnt_q == CNT_DAT_LAST)
    begin
      lk_d.dat = {lk_q.sh[6:0], i_si};
      lk_d.have_dat = 1'b1;
    end
  end

  always_ff @(posedge i_sclk)
  begin
    lk_q <= lk_d;
  end

  // Read data shifts out on the falling edge, ahead of the host's sampling edge
  logic [7:0] rd_byte;
  logic rd_active;
  always_comb
  begin
    rd_byte = 8'h00;
    rd_active = 1'b0;
    if (lk_q.have_op && cnt_q >= 5'h08)
    begin
      unique case (lk_q.op)
        OP_RDSR1:
        begin
          rd_byte = lk_q.st_s2[7:0];
          rd_active = 1'b1;
        end
        OP_RDSR2:
        begin
          rd_byte = lk_q.st_s2[15:8];
          rd_active = 1'b1;
        end
        OP_RDSR3:
        begin
          rd_byte = lk_q.st_s2[23:16];
          rd_active = 1'b1;
        end
        default:
        begin
          rd_active = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end
    else
    begin
      so_q <= rd_byte[3'd7 - cnt_q[2:0]];
      so_oe_q <= rd_active;
    end
  end

  assign o_so = so_q;
  assign o_so_oe = so_oe_q;

  // Core domain

  typedef struct packed {
    logic [SR_W-1:0] nv;
    logic [SR_W-1:0] live;
    logic wr_latch;
    logic vwel;
    logic susp;
    otp_e otp;
    logic perm;
    logic locks_set;
    logic rst_en;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic wp_s1;
    logic wp_s2;
    logic hr_s1;
    logic hr_s2;
  } core_s;

  core_s c_q;
  core_s c_d;
  logic frame_end;
  logic wr_allowed;
  logic is_wr;
  logic [1:0] wr_idx;
  logic [7:0] op;

  assign frame_end = c_q.cs_s2 && !c_q.cs_s3;
  assign op = lk_q.op;
  localparam logic [SR_W-1:0] KEEP_MASK = (SR_W'(1) << BIT_LOCKDOWN) | (SR_W'(3'h7) << BIT_LB_LO);

  always_comb
  begin
    status_word = c_q.live;
    status_word[BIT_WR_LATCH] = c_q.wr_latch | c_q.vwel;
    status_word[BIT_SUSPEND] = c_q.susp;
    status_word[10] = 1'b0;
    status_word[20:19] = 2'b00;
    status_word[23] = 1'b0;
    status_word[0] = 1'b0;
  end

  // WP only counts in standard/dual operation; a permanent lock beats all else
  always_comb
  begin
    wr_allowed = (c_q.wr_latch || c_q.vwel)
      && !c_q.live[BIT_LOCKDOWN]
      && !c_q.perm
      && !(c_q.live[BIT_PROTECT] && !c_q.wp_s2 && !c_q.live[BIT_QUAD]);
    is_wr = (op == OP_WRSR1) || (op == OP_WRSR2) || (op == OP_WRSR3);
    wr_idx = (op == OP_WRSR1) ? 2'd0 : ((op == OP_WRSR2) ? 2'd1 : 2'd2);
  end

  always_comb
  begin
    c_d = c_q;
    c_d.cs_s1 = i_cs_n;
    c_d.cs_s2 = c_q.cs_s1;
    c_d.cs_s3 = c_q.cs_s2;
    c_d.wp_s1 = i_wp_n;
    c_d.wp_s2 = c_q.wp_s1;
    c_d.hr_s1 = i_hw_reset_n;
    c_d.hr_s2 = c_q.hr_s1;
    if (!c_q.hr_s2)
    begin
      // Hardware reset pin: reload volatile copies, keep lock-down and security locks
      c_d.live = (c_q.nv & ~KEEP_MASK) | (c_q.live & KEEP_MASK);
      c_d.live[BIT_ADDR_MODE] = c_q.nv[BIT_PWRUP_MODE];
      c_d.wr_latch = 1'b0;
      c_d.vwel = 1'b0;
      c_d.susp = 1'b0;
      c_d.locks_set = 1'b1;
      c_d.otp = OTP_IDLE;
      c_d.rst_en = 1'b0;
    end
    else if (frame_end && lk_q.have_op)
    begin
      c_d.rst_en = (op == OP_RSTEN);
      c_d.otp = OTP_IDLE;
      unique case (op)
        OP_WREN:
        begin
          c_d.wr_latch = 1'b1;
        end
        OP_VWREN:
        begin
          c_d.vwel = 1'b1;
        end
        OP_WRDI, OP_PROG, OP_ERASE4K:
        begin
          c_d.wr_latch = 1'b0;
          c_d.vwel = 1'b0;
        end
        OP_SUSPEND:
        begin
          c_d.susp = 1'b1;
        end
        OP_RESUME:
        begin
          c_d.susp = 1'b0;
        end
        OP_EN4B:
        begin
          c_d.live[BIT_ADDR_MODE] = 1'b1;
        end
        OP_EX4B:
        begin
          c_d.live[BIT_ADDR_MODE] = 1'b0;
        end
        OP_OTP_PRE1:
        begin
          c_d.otp = OTP_PRE1;
        end
        OP_OTP_PRE2:
        begin
          c_d.otp = (c_q.otp == OTP_PRE1) ? OTP_ARMED : OTP_IDLE;
        end
        OP_RST:
        begin
          if (c_q.rst_en)
          begin
            c_d.live = (c_q.nv & ~KEEP_MASK) | (c_q.live & KEEP_MASK);
            c_d.live[BIT_ADDR_MODE] = c_q.nv[BIT_PWRUP_MODE];
            c_d.wr_latch = 1'b0;
            c_d.vwel = 1'b0;
            c_d.susp = 1'b0;
            c_d.locks_set = 1'b1;
          end
        end
        default:
        begin
          if (is_wr && lk_q.have_dat && wr_allowed)
          begin
            c_d.live = sr_merge(c_q.live, wr_idx, lk_q.dat, c_q.wr_latch);
            if (c_q.wr_latch)
            begin
              c_d.nv = sr_merge(c_q.nv, wr_idx, lk_q.dat, 1'b1);
            end
            // Lock-down is never kept in the non-volatile copy; security locks only set
            c_d.nv[BIT_LOCKDOWN] = 1'b0;
            if ((c_q.otp == OTP_ARMED) && (wr_idx == 2'd1) && lk_q.dat[0])
            begin
              c_d.perm = 1'b1;
            end
            c_d.wr_latch = 1'b0;
            c_d.vwel = 1'b0;
          end
          // A refused write falls through here with the status word and write enable latches untouched
        end
      endcase
    end
    if (i_rst)
    begin
      // Power cycle: factory defaults, lock-down and suspend cleared
      c_d = '0;
      c_d.nv = SR_RESET;
      c_d.live = SR_RESET;
      c_d.otp = OTP_IDLE;
      c_d.locks_set = 1'b1;
      c_d.cs_s1 = 1'b1;
      c_d.cs_s2 = 1'b1;
      c_d.cs_s3 = 1'b1;
      c_d.wp_s1 = 1'b1;
      c_d.wp_s2 = 1'b1;
      c_d.hr_s1 = 1'b1;
      c_d.hr_s2 = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    c_q <= c_d;
  end

  // Block lock bits stay set until a per-block unlock, which lives elsewhere
  assign o_write_enable_latch = c_q.wr_latch | c_q.vwel;
  assign o_suspend_flag = c_q.susp;
  assign o_quad_enable_bit = c_q.live[BIT_QUAD];
  assign o_hold_enable = !c_q.live[BIT_QUAD];
  assign o_current_addr_mode = c_q.live[BIT_ADDR_MODE];
  assign o_ext_addr_required = !c_q.live[BIT_ADDR_MODE];
  assign o_protect_scheme_select = c_q.live[BIT_SCHEME];
  assign o_complement_protect_bit = c_q.live[BIT_COMPL] & !c_q.live[BIT_SCHEME];
  assign o_top_bottom_select = c_q.live[BIT_TOPBOT] & !c_q.live[BIT_SCHEME];
  assign o_block_protect_field = c_q.live[BIT_BLKPROT_LO +: 4] & {4{!c_q.live[BIT_SCHEME]}};
  assign o_block_locks_set = c_q.locks_set & c_q.live[BIT_SCHEME];
  assign o_security_lock = c_q.live[BIT_LB_LO +: 3];
  assign o_drive_strength = c_q.live[BIT_DRV_LO +: 2];
  assign o_drive_pct = drv_decode(c_q.live[BIT_DRV_LO +: 2]);
  assign o_status_lockdown_bit = c_q.live[BIT_LOCKDOWN];
  assign o_status_permanent = c_q.perm;

endmodule

// ==== spi_host_model.sv ====
// Serial host model that issues status instructions
`timescale 1ns/1ps
module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // Clock idles low; data flips after a frame so a stale bit never looks valid
  task automatic frame(input logic [7:0] op, dat, input int n, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    rd = 8'h00;
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #8 o_si = sh[15 - i];
      #8 o_sclk = 1'b1;
      rd = {rd[6:0], i_so};
      #16 o_sclk = 1'b0;
    end
    #8 o_cs_n = 1'b1;
    o_si = ~o_si;
    #300;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the flash status registers
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wp_n = 1'b1;
  logic i_hw_reset_n = 1'b1;
  logic i_sclk, i_cs_n, i_si, o_so, o_so_oe, o_write_enable_latch, o_suspend_flag;
  logic o_quad_enable_bit, o_hold_enable, o_current_addr_mode, o_ext_addr_required;
  logic o_protect_scheme_select, o_complement_protect_bit, o_top_bottom_select;
  logic o_block_locks_set, o_status_lockdown_bit, o_status_permanent;
  logic [3:0] o_block_protect_field;
  logic [2:0] o_security_lock;
  logic [1:0] o_drive_strength;
  logic [6:0] o_drive_pct;
  logic [6:0] pct [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (cycles++ == 20000) conclude();
  flash_status_config_regs uut (.*);
  spi_host_model host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so));
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    ck({7'h00, got}, {7'h00, exp});
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat = 8'h00);
    logic [7:0] r;
    host.frame(op, dat, (op == 8'h01 || op == 8'h31 || op == 8'h11) ? 16 : 8, r);
    @(negedge i_clk);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] dat);
    cmd(8'h06);
    cmd(op, dat);
  endtask
  task automatic rs(input logic [7:0] op, input logic [7:0] exp);
    logic [7:0] r;
    host.frame(op, 8'h00, 16, r);
    ck(r, exp);
  endtask
  task automatic conclude;
    if (cycles > 20000) bad_count++;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    rs(8'h15, 8'h60);
    ck({1'b0, o_drive_pct}, 8'h19);
    cb(o_hold_enable, 1'b1);
    cb(o_so_oe, 1'b0);
    $display("reset done");
  endtask
  task automatic t_latch;
    cmd(8'h06);
    rs(8'h05, 8'h02);
    cmd(8'h04);
    cb(o_write_enable_latch, 1'b0);
    cmd(8'h31, 8'h02);
    rs(8'h35, 8'h00);
    $display("latch done");
  endtask
  task automatic t_wp;
    @(posedge i_clk) i_wp_n <= 1'b0;
    wr(8'h31, 8'h02);
    cb(o_hold_enable, 1'b0);
    wr(8'h01, 8'h80);
    wr(8'h31, 8'h00);
    cb(o_quad_enable_bit, 1'b0);
    wr(8'h31, 8'h02);
    rs(8'h05, 8'h82);
    @(posedge i_clk) i_wp_n <= 1'b1;
    cmd(8'h31, 8'h02);
    cb(o_quad_enable_bit, 1'b1);
    wr(8'h31, 8'h00);
    wr(8'h01, 8'h00);
    rs(8'h05, 8'h00);
    $display("protect done");
  endtask
  task automatic t_sus;
    cmd(8'h75);
    rs(8'h35, 8'h80);
    cmd(8'h7a);
    cb(o_suspend_flag, 1'b0);
    $display("suspend done");
  endtask
  task automatic t_drive;
    for (int v = 0; v < 4; v++)
    begin
      wr(8'h11, {1'b0, v[1:0], 5'h00});
      ck({1'b0, o_drive_pct}, {1'b0, pct[v]});
    end
    wr(8'h11, 8'h78);
    rs(8'h15, 8'h60);
    $display("drive done");
  endtask
  task automatic t_scheme;
    wr(8'h01, 8'h44);
    wr(8'h31, 8'h40);
    ck({o_complement_protect_bit, o_top_bottom_select, 2'h0, o_block_protect_field}, 8'hc1);
    wr(8'h11, 8'h64);
    cb(o_block_locks_set, 1'b1);
    cb(o_protect_scheme_select, 1'b1);
    ck({o_complement_protect_bit, o_top_bottom_select, 2'h0, o_block_protect_field}, 8'h00);
    rs(8'h15, 8'h64);
    wr(8'h11, 8'h60);
    wr(8'h31, 8'h00);
    wr(8'h01, 8'h00);
    $display("scheme done");
  endtask
  task automatic t_addr;
    cmd(8'h50);
    cmd(8'h11, 8'h62);
    rs(8'h15, 8'h60);
    wr(8'h11, 8'h62);
    cb(o_current_addr_mode, 1'b0);
    @(posedge i_clk) i_hw_reset_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_hw_reset_n <= 1'b1;
    repeat (8) @(negedge i_clk);
    rs(8'h15, 8'h63);
    cb(o_ext_addr_required, 1'b0);
    cmd(8'he9);
    cb(o_current_addr_mode, 1'b0);
    cmd(8'hb7);
    cb(o_current_addr_mode, 1'b1);
    cmd(8'he9);
    cmd(8'h66);
    cmd(8'h99);
    cb(o_current_addr_mode, 1'b1);
    cmd(8'h06);
    cmd(8'h02);
    cb(o_write_enable_latch, 1'b0);
    $display("address done");
  endtask
  task automatic t_lock;
    wr(8'h31, 8'h08);
    wr(8'h31, 8'h30);
    wr(8'h31, 8'h00);
    ck({5'h00, o_security_lock}, 8'h07);
    wr(8'h31, 8'h01);
    wr(8'h31, 8'h02);
    rs(8'h35, 8'h39);
    cb(o_status_permanent, 1'b0);
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(negedge i_clk);
    cb(o_status_lockdown_bit, 1'b0);
    cmd(8'h06);
    cmd(8'haa);
    cmd(8'h55);
    cmd(8'h31, 8'h01);
    cb(o_status_permanent, 1'b1);
    wr(8'h31, 8'h02);
    rs(8'h35, 8'h01);
    $display("lock done");
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(negedge i_clk);
    t_reset();
    t_latch();
    t_wp();
    t_sus();
    t_drive();
    t_scheme();
    t_addr();
    t_lock();
    conclude();
  end
endmodule
